/* File: testbench/timer0_counter_props.sv */
`timescale 1ns/10ps
module timer0_counter_props (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic [2:0] clock_select_i,
	input  wire logic [1:0] wave_mode_i,
	input  wire logic       count_we_i,
	input  wire logic [7:0] count_wdata_i,
	input  wire logic [2:0] flags_clear_i,
	input  wire logic [2:0] timer_irq_mask_i,
	input  wire logic [7:0] count_value_o,
	input  wire logic [7:0] compare_value_a_o,
	input  wire logic [2:0] timer_irq_flags_o,
	input  wire logic [2:0] irq_request_o,
	input  wire logic       timer_tick_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire run = clock_select_i == 3'h1 && !count_we_i && wave_mode_i == 2'h0;
	property p_wr; count_we_i |=> count_value_o == $past(count_wdata_i); endproperty
	a_wr: assert property (p_wr) else $error("count write lost");
	property p_inc; run && $past(run) |=> count_value_o == $past(count_value_o) + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("no step at full rate");
	property p_stop; (clock_select_i == 3'h0 && !count_we_i) [*2] |=> $stable(count_value_o); endproperty
	a_stop: assert property (p_stop) else $error("count moved while stopped");
	property p_t0; (clock_select_i == 3'h0) [*3] |-> !timer_tick_o; endproperty
	a_t0: assert property (p_t0) else $error("tick while stopped");
	property p_t1; (clock_select_i == 3'h1) [*3] |-> timer_tick_o; endproperty
	a_t1: assert property (p_t1) else $error("tick missing");
	property p_irq; irq_request_o == (timer_irq_flags_o & $past(timer_irq_mask_i)); endproperty
	a_irq: assert property (p_irq) else $error("request not masked flag");
	property p_ovf; run && count_value_o == 8'hFF |-> ##[1:2] timer_irq_flags_o[0]; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag missing");
	property p_ma; run && $past(run) && count_value_o == compare_value_a_o |-> ##[1:2] timer_irq_flags_o[1]; endproperty
	a_ma: assert property (p_ma) else $error("match flag missing");
	property p_clr; (clock_select_i == 3'h0) [*3] ##0 flags_clear_i[1] |=> !timer_irq_flags_o[1]; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	c_ovf: cover property (run && count_value_o == 8'hFF);
	c_irq: cover property (irq_request_o[1]);
	c_ext: cover property (clock_select_i == 3'h7 && timer_tick_o);
endmodule

/* File: testbench/timer0_counter_tb.sv */
`timescale 1ns/10ps
module timer0_counter_tb;
	logic       mclk_i = 1'b0, rst_n_i = 1'b0, ext_count_pin_i = 1'b0, count_we_i = 1'b0;
	logic       cmp_a_we_i = 1'b0, cmp_b_we_i = 1'b0, timer_tick_o, wave_out_a_o, wave_out_b_o;
	logic [1:0] wave_mode_i = 2'h0;
	logic [2:0] clock_select_i = 3'h0, flags_clear_i = 3'h0, timer_irq_mask_i = 3'h3;
	logic [2:0] timer_irq_flags_o, irq_request_o;
	logic [7:0] count_wdata_i = 8'h00, cmp_a_wdata_i = 8'h00, cmp_b_wdata_i = 8'h00;
	logic [7:0] count_value_o, compare_value_a_o, compare_value_b_o;
	int         error_cnt = 0, check_count = 0, ticks = 0, cyc = 0, r;
	int         div[4] = '{8, 64, 256, 1024};
	logic [16:0] expq[$];
	event       done_ev;
	timer0_counter i_timer0_counter (.*);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic note(input logic [16:0] e);
		expq.push_back(e);
		->done_ev;
		#1;
		$display("test end at %0t", $time);
	endtask
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	// Ceiling well above the ~3000 cycles the tests need
	always @(posedge mclk_i) begin
		cyc++;
		ticks += timer_tick_o;
		if (cyc > 6000) begin
			error_cnt++;
			complete_run();
		end
	end
	always @(done_ev) begin
		if (expq[0][16])
			check({compare_value_a_o, compare_value_b_o}, 16'(expq.pop_front()));
		else if (expq[0][15])
			check({1'b1, 7'h0, wave_out_a_o, wave_out_b_o, irq_request_o, timer_irq_flags_o},
			      16'(expq.pop_front()));
		else
			check(16'(ticks), 16'(expq.pop_front()));
	end
	initial begin
		r = $urandom(66);
		cyc_n(2);
		rst_n_i = 1'b1;
		cyc_n(4);
		// Window of 2N cycles gives exactly 2 ticks only if the prescaler never restarts
		for (int s = 0; s < 6; s++) begin
			clock_select_i = 3'(s);
			cyc_n(3);
			ticks = 0;
			cyc_n(s < 2 ? 8 : 2 * div[s - 2]);
			note(s == 0 ? 0 : s == 1 ? 8 : 2);
		end
		for (int s = 6; s < 8; s++) begin
			clock_select_i = 3'(s);
			cyc_n(3);
			ticks = 0;
			repeat (8) begin
				ext_count_pin_i = ~ext_count_pin_i;
				cyc_n(2);
			end
			cyc_n(4);
			note(4);
		end
		clock_select_i = 3'h0;
		cyc_n(3);
		flags_clear_i = 3'h7;
		cyc_n(1);
		flags_clear_i = 3'h0;
		r = $urandom_range(8'hD0, 8'h20);
		{count_we_i, cmp_a_we_i, cmp_b_we_i} = 3'h7;
		count_wdata_i = 8'h00;
		cmp_a_wdata_i = 8'(r);
		cmp_b_wdata_i = 8'(r + 8);
		cyc_n(1);
		{count_we_i, cmp_a_we_i, cmp_b_we_i} = 3'h0;
		clock_select_i = 3'h1;
		cyc_n(r + 12);
		clock_select_i = 3'h0;
		cyc_n(3);
		note(16'h8016);
		flags_clear_i = 3'h7;
		count_we_i = 1'b1;
		count_wdata_i = 8'hF0;
		timer_irq_mask_i = 3'h5;
		cyc_n(1);
		flags_clear_i = 3'h0;
		count_we_i = 1'b0;
		clock_select_i = 3'h1;
		cyc_n(30);
		clock_select_i = 3'h0;
		cyc_n(3);
		note(16'h8009);
		// PWM mode, stopped: a compare write only reaches the buffer
		wave_mode_i = 2'h2;
		cmp_a_we_i = 1'b1;
		cmp_a_wdata_i = 8'h00;
		cyc_n(1);
		cmp_a_we_i = 1'b0;
		cyc_n(3);
		note({1'b1, 8'h00, 8'(r + 8)});
		note(16'h80C9);
		complete_run();
	end
endmodule
bind timer0_counter timer0_counter_props i_timer0_counter_props (.*);

/* File: verilog/ext_edge_detect.sv */
`timescale 1ns/10ps
module ext_edge_detect (
	input  wire logic mclk_i,
	input  wire logic rst_n,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	typedef struct packed {
		logic sampled;
		logic last;
		logic [1:0] filled;
	} edge_state_t;

	edge_state_t state;
	edge_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.sampled = pin_i;
		next_state.last = state.sampled;
		next_state.filled = {state.filled[0], 1'b1};
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	// No edges until both stages hold real samples: a pin high at reset is no rise
	assign rise_o = state.filled[1] & state.sampled & ~state.last;
	assign fall_o = state.filled[1] & ~state.sampled & state.last;
endmodule

/* File: verilog/timer0_counter.sv */
// Behaviour
// - Counter and both compare values are 8-bit.
// - Two compare units drive waveform outputs, PWM.
// - Compare both units against counter every cycle.
// - Match sets that unit's compare flag.
// - Overflow, match A, match B interrupt sources.
// - Shared flag register, individually masked requests.
// - Count prescaled internal clock or external pin.
// - Clock select picks source and edge.
// - No source selected means no counting.
// - Select 1 counts at system clock rate.
// - Prescaler taps divide by 8/64/256/1024.
// - Prescaler free running, unaffected by select.
// - Zero is the bottom of the range.
// - 255 is the maximum of the range.
// - Top is 255 or compare A by mode.
// - Compare values double-buffered in PWM modes.
// - Select 0 stops; counter still writable.
// - Select 7 rising, 6 falling external edges.
// - First prescaled count after 1 to N clocks.
`timescale 1ns/10ps
`include "timer0_defs.svh"
module timer0_counter
	import timer0_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic [2:0] clock_select_i,
	input  wire logic [1:0] wave_mode_i,
	input  wire logic       ext_count_pin_i,
	input  wire logic       count_we_i,
	input  wire logic [7:0] count_wdata_i,
	input  wire logic       cmp_a_we_i,
	input  wire logic [7:0] cmp_a_wdata_i,
	input  wire logic       cmp_b_we_i,
	input  wire logic [7:0] cmp_b_wdata_i,
	input  wire logic [2:0] flags_clear_i,
	input  wire logic [2:0] timer_irq_mask_i,
	output logic      [7:0] count_value_o,
	output logic      [7:0] compare_value_a_o,
	output logic      [7:0] compare_value_b_o,
	output logic      [2:0] timer_irq_flags_o,
	output logic      [2:0] irq_request_o,
	output logic            timer_tick_o,
	output logic            wave_out_a_o,
	output logic            wave_out_b_o
);
	typedef struct packed {
		count_t     count;
		count_t     cmp_a;
		count_t     cmp_b;
		count_t     buf_a;
		count_t     buf_b;
		flags_t     flags;
		flags_t     irq;
		logic       block_match;
		logic       tick;
		logic       wave_a;
		logic       wave_b;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;
	logic         rst_n;
	logic [3:0]   taps;
	logic         ext_rise;
	logic         ext_fall;
	logic         tick;
	logic         is_pwm;
	count_t       top;
	logic         at_top;
	logic         match_a;
	logic         match_b;

	// Reset synchroniser runs in its own process: async clear, sync release
	logic [1:0] rst_pipe;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	timer_prescaler u_prescaler (
		.mclk_i (mclk_i),
		.rst_n  (rst_n),
		.tap_o  (taps)
	);

	ext_edge_detect u_edge (
		.mclk_i (mclk_i),
		.rst_n  (rst_n),
		.pin_i  (ext_count_pin_i),
		.rise_o (ext_rise),
		.fall_o (ext_fall)
	);

	function automatic logic select_tick(input logic [2:0] cs, input logic [3:0] tp,
					     input logic rise, input logic fall);
		case (cs)
			`CS_STOP:     select_tick = 1'b0;
			`CS_DIRECT:   select_tick = 1'b1;
			`CS_DIV8:     select_tick = tp[0];
			`CS_DIV64:    select_tick = tp[1];
			`CS_DIV256:   select_tick = tp[2];
			`CS_DIV1024:  select_tick = tp[3];
			`CS_EXT_FALL: select_tick = fall;
			default:      select_tick = rise;
		endcase
	endfunction

	assign tick    = select_tick(clock_select_i, taps, ext_rise, ext_fall);
	assign is_pwm  = wave_mode_i[1];
	// Top follows compare A only in the CTC and top-A PWM modes
	assign top     = (wave_mode_i == `MODE_CTC || wave_mode_i == `MODE_PWM_TOP_A) ?
			 state.cmp_a : `CNT_MAX;
	assign at_top  = (state.count == top);
	assign match_a = (state.count == state.cmp_a);
	assign match_b = (state.count == state.cmp_b);

	always_comb begin
		next_state = state;
		next_state.tick = tick;

		// Flags: clear first so a same-cycle set wins
		next_state.flags = state.flags & ~flags_clear_i;

		if (tick) begin
			next_state.block_match = 1'b0;
			if (!state.block_match) begin
				if (match_a)
					next_state.flags[`FLAG_MATCH_A] = 1'b1;
				if (match_b)
					next_state.flags[`FLAG_MATCH_B] = 1'b1;
			end
			if (at_top) begin
				next_state.count = `CNT_BOTTOM;
				if (top == `CNT_MAX || wave_mode_i != `MODE_CTC)
					next_state.flags[`FLAG_OVF] = 1'b1;
				if (is_pwm) begin
					next_state.cmp_a = state.buf_a;
					next_state.cmp_b = state.buf_b;
				end
			end else begin
				next_state.count = state.count + 8'h01;
			end
		end

		// Waveform: toggle on match outside PWM, set/clear against compare in PWM
		if (is_pwm) begin
			next_state.wave_a = (state.count < state.cmp_a);
			next_state.wave_b = (state.count < state.cmp_b);
		end else if (tick && !state.block_match) begin
			next_state.wave_a = state.wave_a ^ match_a;
			next_state.wave_b = state.wave_b ^ match_b;
		end

		// Software write wins over counting and blocks the next match
		if (count_we_i) begin
			next_state.count = count_wdata_i;
			next_state.block_match = 1'b1;
		end

		// Outside PWM the compare value is written straight through
		if (cmp_a_we_i) begin
			next_state.buf_a = cmp_a_wdata_i;
			if (!is_pwm)
				next_state.cmp_a = cmp_a_wdata_i;
		end
		if (cmp_b_we_i) begin
			next_state.buf_b = cmp_b_wdata_i;
			if (!is_pwm)
				next_state.cmp_b = cmp_b_wdata_i;
		end

		next_state.irq = next_state.flags & timer_irq_mask_i;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign count_value_o     = state.count;
	assign compare_value_a_o = state.buf_a;
	assign compare_value_b_o = state.cmp_b;
	assign timer_irq_flags_o = state.flags;
	assign irq_request_o     = state.irq;
	assign timer_tick_o      = state.tick;
	assign wave_out_a_o      = state.wave_a;
	assign wave_out_b_o      = state.wave_b;
endmodule

/* File: verilog/timer0_defs.svh */
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

`define CNT_BOTTOM     8'h00
`define CNT_MAX        8'hFF
`define CS_STOP        3'h0
`define CS_DIRECT      3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7
`define PRESC_WIDTH    10
`define FLAG_OVF       0
`define FLAG_MATCH_A   1
`define FLAG_MATCH_B   2
`define FLAGS_RESET    3'h0
`define MODE_NORMAL    2'h0
`define MODE_CTC       2'h1
`define MODE_FAST_PWM  2'h2
`define MODE_PWM_TOP_A 2'h3

`endif

/* File: verilog/timer0_pkg.sv */
package timer0_pkg;
	typedef logic [7:0] count_t;
	typedef logic [2:0] flags_t;
	typedef enum logic [1:0] {
		mode_normal,
		mode_ctc,
		mode_fast_pwm,
		mode_pwm_top_a
	} wave_mode_t;
endpackage

/* File: verilog/timer_prescaler.sv */
`timescale 1ns/10ps
`include "timer0_defs.svh"
module timer_prescaler #(
	parameter int WIDTH = `PRESC_WIDTH
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_n,
	output logic      [3:0] tap_o
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
	} presc_state_t;

	presc_state_t state;
	presc_state_t next_state;

	if (WIDTH < 10)
		$error("prescaler needs at least 10 bits for the /1024 tap");

	// Free running: clock select never touches this counter
	always_comb begin
		next_state = state;
		next_state.count = state.count + 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	// One-cycle enables on the wrap of each tap, hence 1..N latency after select
	assign tap_o[0] = &state.count[2:0];
	assign tap_o[1] = &state.count[5:0];
	assign tap_o[2] = &state.count[7:0];
	assign tap_o[3] = &state.count[9:0];
endmodule
